/* core/flash_host_consts.svh */
// constants of the flash host controller: offsets, fields, commands, timing
`ifndef FLASH_HOST_CONSTS_SVH
`define FLASH_HOST_CONSTS_SVH

`define CLK_NS            10
`define T_SETUP_NS        20
`define T_STROBE_NS       70
`define T_HOLD_NS         20
`define SETUP_CYC         ((`T_SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define STROBE_CYC        ((`T_STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define HOLD_CYC          ((`T_HOLD_NS + `CLK_NS - 1) / `CLK_NS)

`define REG_CTRL          8'h00
`define REG_ADDR          8'h04
`define REG_WDATA         8'h08
`define REG_RDATA         8'h0C
`define REG_STATUS        8'h10

`define CTRL_OP_LO        0
`define CTRL_OP_HI        2
`define CTRL_AUTO_CHECK   4
`define CTRL_AUTO_CLEAR   5
`define CTRL_FINAL_RA     6
`define CTRL_RST          3'h0

`define OP_PROGRAM        3'h1
`define OP_READ           3'h2
`define OP_CMD            3'h3
`define OP_CHECK          3'h4

`define STS_BUSY          0
`define STS_RES_LO        1
`define STS_RES_HI        3
`define STS_SR_LO         8
`define STS_SR_HI         15

`define SR_READY          7
`define SR_PROG_FAIL      4
`define SR_SUPPLY         3
`define SR_LOCKED         1

`define CMD_PROGRAM       8'h40
`define CMD_CLEAR_STATUS  8'h50
`define CMD_READ_STATUS   8'h70
`define CMD_READ_ARRAY    8'hFF

`endif

/* core/flash_host_pkg.sv */
// types shared by the flash host controller
package flash_host_pkg;
    typedef enum logic [9:0] {
        ST_IDLE   = 10'h001,
        ST_SETUP  = 10'h002,
        ST_DATA   = 10'h004,
        ST_POLL   = 10'h008,
        ST_CHECK  = 10'h010,
        ST_CLEAR  = 10'h020,
        ST_RDARR  = 10'h040,
        ST_READ   = 10'h080,
        ST_CMD    = 10'h100,
        ST_STSCMD = 10'h200
    } ctlState_t;

    typedef enum logic [3:0] {
        PH_IDLE   = 4'h1,
        PH_SETUP  = 4'h2,
        PH_STROBE = 4'h4,
        PH_HOLD   = 4'h8
    } busPhase_t;

    typedef enum logic [2:0] {
        RES_NONE   = 3'h0,
        RES_OK     = 3'h1,
        RES_SUPPLY = 3'h2,
        RES_PROG   = 3'h3,
        RES_LOCKED = 3'h4
    } result_t;
endpackage

/* core/flash_bus_cycle.sv */
// one asynchronous flash bus cycle: chip select, strobe, hold, release
`timescale 1ns/100ps
`include "flash_host_consts.svh"
module flash_bus_cycle #(
    parameter int AW = 22,
    parameter int DW = 16
) (
    input  wire logic          coreClk,
    input  wire logic          srst,
    input  wire logic          start,
    input  wire logic          wr,
    input  wire logic [AW-1:0] addrIn,
    input  wire logic [DW-1:0] dataIn,
    output logic               ready,
    output logic               done,
    output logic [DW-1:0]      rdData,
    output logic [AW-1:0]      flashAddr,
    output logic               ceN,
    output logic               oeN,
    output logic               weN,
    input  wire logic [DW-1:0] dqIn,
    output logic [DW-1:0]      dqOut,
    output logic               dqOeN
);
    import flash_host_pkg::*;

    localparam logic [3:0] SETUP_N  = 4'(`SETUP_CYC);
    localparam logic [3:0] STROBE_N = 4'(`STROBE_CYC);
    localparam logic [3:0] HOLD_N   = 4'(`HOLD_CYC);

    if (DW < 8 || AW < 1) begin : g_chk
        $error("flash_bus_cycle: unsupported width");
    end

    busPhase_t  phase_q;
    logic [3:0] cnt_q;
    logic       wr_q;

    assign ready = (phase_q == PH_IDLE);

    // chip select falls and rises once per cycle, so every status read is fresh
    always_ff @(posedge coreClk) begin
        if (srst) begin
            phase_q <= PH_IDLE;
            cnt_q   <= 4'h0;
            wr_q    <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            case (phase_q)
                PH_IDLE: begin
                    if (start) begin
                        phase_q <= PH_SETUP;
                        cnt_q   <= SETUP_N;
                        wr_q    <= wr;
                    end
                end
                PH_SETUP: begin
                    cnt_q <= cnt_q - 4'h1;
                    if (cnt_q == 4'h1) begin
                        phase_q <= PH_STROBE;
                        cnt_q   <= STROBE_N;
                    end
                end
                PH_STROBE: begin
                    cnt_q <= cnt_q - 4'h1;
                    if (cnt_q == 4'h1) begin
                        phase_q <= PH_HOLD;
                        cnt_q   <= HOLD_N;
                    end
                end
                PH_HOLD: begin
                    cnt_q <= cnt_q - 4'h1;
                    if (cnt_q == 4'h1) begin
                        phase_q <= PH_IDLE;
                        done    <= 1'b1;
                    end
                end
                default: phase_q <= PH_IDLE;
            endcase
        end
    end

    always_ff @(posedge coreClk) begin
        if (srst) begin
            ceN <= 1'b1;
            oeN <= 1'b1;
            weN <= 1'b1;
            dqOeN <= 1'b1;
        end else begin
            ceN   <= !((phase_q == PH_IDLE && start) || (phase_q != PH_IDLE && !done
                       && !(phase_q == PH_HOLD && cnt_q == 4'h1)));
            oeN   <= !(phase_q == PH_SETUP && cnt_q == 4'h1 && !wr_q
                       || phase_q == PH_STROBE && cnt_q != 4'h1 && !wr_q);
            weN   <= !(phase_q == PH_SETUP && cnt_q == 4'h1 && wr_q
                       || phase_q == PH_STROBE && cnt_q != 4'h1 && wr_q);
            // data stays driven through hold so the latch edge sees it stable
            dqOeN <= !((phase_q == PH_IDLE && start && wr)
                       || (phase_q != PH_IDLE && wr_q && !(phase_q == PH_HOLD && cnt_q == 4'h1)));
        end
    end

    always_ff @(posedge coreClk) begin
        if (srst) begin
            flashAddr <= '0;
            dqOut     <= '0;
            rdData    <= '0;
        end else begin
            if (phase_q == PH_IDLE && start) begin
                flashAddr <= addrIn;
                dqOut     <= dataIn;
            end
            if (phase_q == PH_STROBE && cnt_q == 4'h1 && !wr_q) begin
                rdData <= dqIn;
            end
        end
    end

    AST_CE_TOGGLE: assert property (@(posedge coreClk) disable iff (srst)
        (ready && start) |-> ceN ##1 !ceN)
        else $error("cycle started without chip select released first");
endmodule

/* core/flash_host_ctrl.sv */
// wishbone-controlled host sequencer driving a boot-block nor flash
//
// Chosen here: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
`include "flash_host_consts.svh"
// Functional notes
// - program is setup byte then data write
// - chip select toggles between status polls
// - read-array command written after final program
// - check supply, then failure, then locked flag
// - clear status after any found error
module flash_host_ctrl #(
    parameter int AW = 22,
    parameter int DW = 16
) (
    input  wire logic          coreClk,
    input  wire logic          srst,
    input  wire logic          wbCyc,
    input  wire logic          wbStb,
    input  wire logic          wbWe,
    input  wire logic [7:0]    wbAdr,
    input  wire logic [3:0]    wbSel,
    input  wire logic [31:0]   wbDatW,
    output logic [31:0]        wbDatR,
    output logic               wbAck,
    output logic [AW-1:0]      flashAddr,
    output logic               ceN,
    output logic               oeN,
    output logic               weN,
    input  wire logic [DW-1:0] dqIn,
    output logic [DW-1:0]      dqOut,
    output logic               dqOeN
);
    import flash_host_pkg::*;

    if (AW > 32 || DW > 32 || DW < 8) begin : g_chk
        $error("flash_host_ctrl: unsupported width");
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // supply range first, then failure, then locked block
    function automatic result_t checkStatus(input logic [7:0] sr);
        if (sr[`SR_SUPPLY]) begin
            return RES_SUPPLY;
        end else if (sr[`SR_PROG_FAIL]) begin
            return RES_PROG;
        end else if (sr[`SR_LOCKED]) begin
            return RES_LOCKED;
        end
        return RES_OK;
    endfunction

    ctlState_t      state_q;
    logic [6:0]     ctrl_q;
    logic [31:0]    addr_q;
    logic [31:0]    wdata_q;
    logic [DW-1:0]  rdata_q;
    logic [7:0]     sr_q;
    result_t        result_q;
    logic           inFlight_q;
    logic [7:0]     lastWr_q;
    logic           wasProg_q;

    logic           busReady;
    logic           busDone;
    logic [DW-1:0]  busRd;
    logic           needCycle;
    logic           busStart;
    logic           cycWr;
    logic [DW-1:0]  cycData;
    logic           wbWrite;
    logic           startOp;
    logic           busy;

    assign busy    = (state_q != ST_IDLE);
    // writes land on the ack edge, the one at which the master samples the answer
    assign wbWrite = wbCyc && wbStb && wbWe && wbAck;
    assign startOp = wbWrite && wbAdr == `REG_CTRL && wbSel[0] && !busy
                     && wbDatW[`CTRL_OP_HI:`CTRL_OP_LO] != 3'h0;

    always_comb begin
        needCycle = !inFlight_q && !(state_q == ST_IDLE || state_q == ST_CHECK);
        cycWr     = !(state_q == ST_POLL || state_q == ST_READ);
        case (state_q)
            ST_SETUP:  cycData = DW'(`CMD_PROGRAM);
            ST_CLEAR:  cycData = DW'(`CMD_CLEAR_STATUS);
            ST_RDARR:  cycData = DW'(`CMD_READ_ARRAY);
            ST_STSCMD: cycData = DW'(`CMD_READ_STATUS);
            default:   cycData = wdata_q[DW-1:0];
        endcase
    end
    assign busStart = needCycle && busReady;

    flash_bus_cycle #(.AW(AW), .DW(DW)) u_cycle (
        .coreClk   (coreClk),
        .srst      (srst),
        .start     (busStart),
        .wr        (cycWr),
        .addrIn    (addr_q[AW-1:0]),
        .dataIn    (cycData),
        .ready     (busReady),
        .done      (busDone),
        .rdData    (busRd),
        .flashAddr (flashAddr),
        .ceN       (ceN),
        .oeN       (oeN),
        .weN       (weN),
        .dqIn      (dqIn),
        .dqOut     (dqOut),
        .dqOeN     (dqOeN)
    );

    always_ff @(posedge coreClk) begin
        if (srst) begin
            ctrl_q  <= 7'h0;
            addr_q  <= 32'h0;
            wdata_q <= 32'h0;
        end else if (wbWrite && !busy) begin
            // settings are frozen while an operation runs
            case (wbAdr)
                `REG_CTRL:  ctrl_q  <= 7'(merge({25'h0, ctrl_q}, wbDatW, wbSel));
                `REG_ADDR:  addr_q  <= merge(addr_q, wbDatW, wbSel);
                `REG_WDATA: wdata_q <= merge(wdata_q, wbDatW, wbSel);
                default:    ;
            endcase
        end
    end

    always_ff @(posedge coreClk) begin
        if (srst) begin
            wbAck  <= 1'b0;
            wbDatR <= 32'h0;
        end else begin
            wbAck <= wbCyc && wbStb && !wbAck;
            case (wbAdr)
                `REG_CTRL:   wbDatR <= {25'h0, ctrl_q[`CTRL_FINAL_RA:`CTRL_AUTO_CHECK], 4'h0};
                `REG_ADDR:   wbDatR <= addr_q;
                `REG_WDATA:  wbDatR <= wdata_q;
                `REG_RDATA:  wbDatR <= 32'(rdata_q);
                `REG_STATUS: wbDatR <= {16'h0, sr_q, 4'h0, result_q, busy};
                default:     wbDatR <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge coreClk) begin
        if (srst) begin
            inFlight_q <= 1'b0;
        end else if (busStart) begin
            inFlight_q <= 1'b1;
        end else if (busDone) begin
            inFlight_q <= 1'b0;
        end
    end

    always_ff @(posedge coreClk) begin
        if (srst) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (startOp) begin
                        case (wbDatW[`CTRL_OP_HI:`CTRL_OP_LO])
                            `OP_PROGRAM: state_q <= ST_SETUP;
                            `OP_READ:    state_q <= ST_READ;
                            `OP_CMD:     state_q <= ST_CMD;
                            default:     state_q <= ST_STSCMD;
                        endcase
                    end
                end
                ST_SETUP:  if (busDone) state_q <= ST_DATA;
                ST_DATA:   if (busDone) state_q <= ST_POLL;
                ST_STSCMD: if (busDone) state_q <= ST_POLL;
                ST_POLL: begin
                    // busy status repeats the poll with a fresh chip select
                    if (busDone && busRd[`SR_READY]) begin
                        if (ctrl_q[`CTRL_AUTO_CHECK]) begin
                            state_q <= ST_CHECK;
                        end else if (ctrl_q[`CTRL_FINAL_RA]) begin
                            state_q <= ST_RDARR;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_CHECK: begin
                    if (checkStatus(sr_q) != RES_OK && ctrl_q[`CTRL_AUTO_CLEAR]) begin
                        state_q <= ST_CLEAR;
                    end else if (ctrl_q[`CTRL_FINAL_RA]) begin
                        state_q <= ST_RDARR;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_CLEAR:  if (busDone) state_q <= ctrl_q[`CTRL_FINAL_RA] ? ST_RDARR : ST_IDLE;
                ST_RDARR:  if (busDone) state_q <= ST_IDLE;
                ST_READ:   if (busDone) state_q <= ST_IDLE;
                ST_CMD:    if (busDone) state_q <= ST_IDLE;
                default:   state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge coreClk) begin
        if (srst) begin
            sr_q     <= 8'h80;
            result_q <= RES_NONE;
            rdata_q  <= '0;
        end else begin
            if (startOp) begin
                result_q <= RES_NONE;
            end
            if (state_q == ST_POLL && busDone) begin
                sr_q <= busRd[7:0];
            end
            if (state_q == ST_CHECK) begin
                result_q <= checkStatus(sr_q);
            end
            if (state_q == ST_READ && busDone) begin
                rdata_q <= busRd;
            end
        end
    end

    // helper state for the checks below
    always_ff @(posedge coreClk) begin
        if (srst) begin
            lastWr_q  <= 8'h00;
            wasProg_q <= 1'b0;
        end else begin
            if (busStart && cycWr) begin
                lastWr_q <= cycData[7:0];
            end
            if (startOp) begin
                wasProg_q <= wbDatW[`CTRL_OP_HI:`CTRL_OP_LO] == `OP_PROGRAM;
            end
        end
    end

    // tied to the states so a data word that looks like the setup byte cannot trigger it
    sequence setupWrite;
        busStart && state_q == ST_SETUP && cycData[7:0] == `CMD_PROGRAM;
    endsequence
    sequence dataWrite;
        busStart && state_q == ST_DATA && cycWr && cycData == wdata_q[DW-1:0];
    endsequence

    AST_PROG_SEQ: assert property (@(posedge coreClk) disable iff (srst)
        setupWrite |-> ##[1:60] dataWrite)
        else $error("program setup not followed by data write");

    AST_FINAL_READ_ARRAY: assert property (@(posedge coreClk) disable iff (srst)
        ($fell(busy) && wasProg_q && ctrl_q[`CTRL_FINAL_RA]) |-> lastWr_q == `CMD_READ_ARRAY)
        else $error("program ended without read-array command");

    AST_CHECK_ORDER: assert property (@(posedge coreClk) disable iff (srst)
        (state_q == ST_CHECK) |=> ((result_q == RES_OK)
            == !(sr_q[`SR_SUPPLY] || sr_q[`SR_PROG_FAIL] || sr_q[`SR_LOCKED]))
            && (sr_q[`SR_SUPPLY] -> result_q == RES_SUPPLY))
        else $error("status check result out of order");

    AST_CLEAR_ON_ERROR: assert property (@(posedge coreClk) disable iff (srst)
        (state_q == ST_CHECK && ctrl_q[`CTRL_AUTO_CLEAR] && checkStatus(sr_q) != RES_OK)
        |-> ##[1:30] (busStart && cycWr && cycData[7:0] == `CMD_CLEAR_STATUS))
        else $error("error found but clear-status not issued");
endmodule

/* tb/flash_dev_model.sv */
// behavioural boot-block flash device answering the host controller's bus cycles
`timescale 1ns/100ps
module flash_dev_model #(
    parameter int          AW        = 22,
    parameter int          DW        = 16,
    parameter logic [15:0] MAKER_CODE = 16'h00A5  // arbitrary identification value
) (
    input  wire logic [AW-1:0] flashAddr,
    input  wire logic          ceN,
    input  wire logic          oeN,
    input  wire logic          weN,
    input  wire logic [DW-1:0] dqOut,
    input  wire logic          dqOeN,
    output logic [DW-1:0]      dqIn,
    input  wire logic          supplyLow,
    input  wire logic          failNext,
    input  wire logic [3:0]    busyReads
);
    typedef enum logic [2:0] {M_ARR, M_STS, M_CFG, M_QRY, M_LSET, M_PSET, M_PRSET,
                              M_ESET} mode_t;
    mode_t         mode = M_ARR;
    logic [7:0]    sr = 8'h00;
    int            busyLeft = 0;
    int            ersLeft = 0;
    bit            erasing = 1'b0;
    bit            ersSusp = 1'b0;
    int            blk;
    logic [DW-1:0] mem [int];
    bit            locked [int];
    logic [DW-1:0] rdVal = '0;
    wire           reading = (ceN === 1'b0) && (oeN === 1'b0);

    assign blk = int'(flashAddr[AW-1:15]);
    // released bus shows the inverse so a stale value never looks valid
    assign dqIn = reading ? rdVal : ~rdVal;

    // commands are ignored while an operation runs, except a suspend during erase
    always @(posedge weN) begin
        if (ceN === 1'b0 && dqOeN === 1'b0
            && (busyLeft == 0 || (erasing && dqOut[7:0] == 8'hB0))) begin
            if (erasing && busyLeft > 0) begin
                ersSusp = 1'b1;
                ersLeft = busyLeft;
                busyLeft = 0;
                mode = M_STS;
            end else if (ersSusp && mode != M_LSET && dqOut[7:0] == 8'hD0) begin
                ersSusp = 1'b0;
                busyLeft = ersLeft;
                mode = M_STS;
            end else if (ersSusp && mode != M_LSET && dqOut[7:0] == 8'hC0) begin
                mode = M_ARR;
            end else case (mode)
                M_PSET: begin
                    mode = M_STS;
                    if (sr[3] || supplyLow) sr[3] = 1'b1;
                    else if (locked.exists(blk)) sr[1] = 1'b1;
                    else if (failNext) sr[4] = 1'b1;
                    else begin
                        mem[int'(flashAddr)] = dqOut;
                        busyLeft = int'(busyReads);
                    end
                end
                M_PRSET: begin
                    mode = M_STS;
                    busyLeft = int'(busyReads);
                end
                M_ESET: begin
                    mode = M_STS;
                    if (dqOut[7:0] == 8'hD0) begin
                        erasing = 1'b1;
                        busyLeft = int'(busyReads);
                    end
                end
                M_LSET: begin
                    mode = M_STS;
                    if (dqOut[7:0] == 8'h01 || dqOut[7:0] == 8'h2F) locked[blk] = 1'b1;
                    else if (dqOut[7:0] == 8'hD0) locked.delete(blk);
                end
                default: begin
                    case (dqOut[7:0])
                        8'h40: mode = M_PSET;
                        8'h70: mode = M_STS;
                        8'h50: begin
                            sr = 8'h00;
                            mode = M_ARR;
                        end
                        8'h90: mode = M_CFG;
                        8'h98: mode = M_QRY;
                        8'h60: mode = M_LSET;
                        8'h20: mode = M_ESET;
                        8'hC0: mode = M_PRSET;
                        8'hFF, 8'h01, 8'h2F: mode = M_ARR;
                        default: ;
                    endcase
                end
            endcase
        end
    end

    // status only refreshes on a fresh read strobe
    always @(posedge reading) begin
        if (busyLeft > 0) busyLeft--;
        case (mode)
            M_ARR: rdVal = mem.exists(int'(flashAddr)) ? mem[int'(flashAddr)] : 16'hFFFF;
            M_QRY: rdVal = (flashAddr == 'h10) ? 16'h0051 : (flashAddr == 'h11) ? 16'h0052 : 16'h0;
            M_CFG: rdVal = MAKER_CODE;
            default: rdVal = {8'h00, busyLeft == 0, 2'b00, sr[4:0]};
        endcase
    end
endmodule

/* tb/testbench.sv */
// self-checking bench: wishbone master, flash host controller and device model
`timescale 1ns/100ps
`include "flash_host_consts.svh"
module testbench;
    logic        coreClk = 1'b0;
    logic        srst, wbCyc, wbStb, wbWe, wbAck, ceN, oeN, weN, dqOeN;
    logic [7:0]  wbAdr;
    logic [3:0]  wbSel, busyReads;
    logic [31:0] wbDatW, wbDatR;
    logic [21:0] flashAddr;
    logic [15:0] dqIn, dqOut;
    logic        supplyLow, failNext;
    int          n_errors = 0;
    int          comparisons = 0;
    integer      seed = 32'h7D52E0D6;

    always #5 coreClk = ~coreClk;

    flash_host_ctrl dut (.coreClk(coreClk), .srst(srst), .wbCyc(wbCyc), .wbStb(wbStb),
        .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR),
        .wbAck(wbAck), .flashAddr(flashAddr), .ceN(ceN), .oeN(oeN), .weN(weN),
        .dqIn(dqIn), .dqOut(dqOut), .dqOeN(dqOeN));
    flash_dev_model dev (.flashAddr(flashAddr), .ceN(ceN), .oeN(oeN), .weN(weN),
        .dqOut(dqOut), .dqOeN(dqOeN), .dqIn(dqIn), .supplyLow(supplyLow),
        .failNext(failNext), .busyReads(busyReads));

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // request held until ack is sampled high, then released for one idle cycle
    task automatic wbXfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
        int n;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatW <= d;
        wbSel <= 4'hF;
        n = 0;
        @(posedge coreClk);
        while (wbAck !== 1'b1 && n < 20) begin
            @(posedge coreClk);
            n++;
        end
        q = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge coreClk);
        if (n >= 20) begin
            n_errors++;
            end_of_test();
        end
    endtask

    task automatic runOp(input logic [21:0] a, input logic [15:0] d, input logic [6:0] ctl,
                         output logic [31:0] s);
        int n;
        wbXfer(1'b1, `REG_ADDR, {10'h0, a}, s);
        wbXfer(1'b1, `REG_WDATA, {16'h0, d}, s);
        wbXfer(1'b1, `REG_CTRL, {25'h0, ctl}, s);
        n = 0;
        do begin
            wbXfer(1'b0, `REG_STATUS, 32'h0, s);
            n++;
        end while (s[0] !== 1'b0 && n < 300);
        if (n >= 300) begin
            n_errors++;
            end_of_test();
        end
    endtask

    task automatic rawCmd(input logic [21:0] a, input logic [7:0] c);
        logic [31:0] s;
        runOp(a, {8'h00, c}, {4'h0, `OP_CMD}, s);
    endtask

    task automatic readWord(input logic [21:0] a, output logic [31:0] q);
        runOp(a, 16'h0, {4'h0, `OP_READ}, q);
        wbXfer(1'b0, `REG_RDATA, 32'h0, q);
    endtask

    // flags checked in priority: supply, then program failure, then lock
    function automatic logic [2:0] expRes(input logic [7:0] f);
        if (f[3]) return 3'h2;
        if (f[4]) return 3'h3;
        if (f[1]) return 3'h4;
        return 3'h1;
    endfunction

    initial begin
        logic [31:0] s, q;
        logic [7:0]  stk;
        logic [21:0] a;
        logic [15:0] d;
        logic        sup, fl, clr, fin, wr;
        logic [2:0]  res;
        srst = 1'b1;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 8'h00;
        wbSel = 4'h0;
        wbDatW = 32'h0;
        supplyLow = 1'b0;
        failNext = 1'b0;
        busyReads = 4'h0;
        stk = 8'h00;
        repeat (3) @(posedge coreClk);
        srst <= 1'b0;
        @(posedge coreClk);
        wbXfer(1'b0, `REG_STATUS, 32'h0, s);
        check(s, 32'h0000_8000);
        wbXfer(1'b1, 8'h14, 32'hFFFF_FFFF, s);
        wbXfer(1'b0, 8'h14, 32'h0, s);
        check(s, 32'h0);
        $display("test reset done");
        rawCmd(22'h018000, 8'h60);
        rawCmd(22'h018000, 8'h01);
        rawCmd(22'h0, 8'h98);
        readWord(22'h10, q);
        check(q & 32'hFFFF, 32'h51);
        readWord(22'h11, q);
        check(q & 32'hFFFF, 32'h52);
        rawCmd(22'h0, `CMD_READ_ARRAY);
        $display("test lock and query done");
        for (int i = 0; i < 16; i++) begin
            a = (i == 0 || i == 15) ? 22'h018004 : 22'({$random(seed)} % 32'h18000);
            d = 16'($random(seed));
            sup = (i == 1) || (($random(seed) & 7) == 0);
            fl = (i == 3) || (($random(seed) & 7) == 0);
            clr = (i == 3) || (i > 3 && i < 15 && $random(seed) & 1);
            fin = 1'($random(seed));
            supplyLow <= sup;
            failNext <= fl;
            busyReads <= 4'({$random(seed)} % 5);
            wr = 1'b0;
            if (stk[3] || sup) stk[3] = 1'b1;
            else if (a[21:15] == 7'd3) stk[1] = 1'b1;
            else if (fl) stk[4] = 1'b1;
            else wr = 1'b1;
            res = expRes(stk);
            runOp(a, d, {fin, clr, 1'b1, 1'b0, `OP_PROGRAM}, s);
            check(s & 32'hFFFF, {16'h0, 8'h80 | stk, 4'h0, res, 1'b0});
            if (clr && res != 3'h1) stk = 8'h00;
            if (wr && fin) begin
                readWord(a, q);
                check(q & 32'hFFFF, {16'h0, d});
            end
        end
        $display("test program loop done");
        runOp(22'h0, 16'h0, {3'b001, 1'b0, `OP_CHECK}, s);
        check(s & 32'hFFFF, {16'h0, 8'h80 | stk, 4'h0, expRes(stk), 1'b0});
        rawCmd(22'h0, `CMD_CLEAR_STATUS);
        runOp(22'h0, 16'h0, {3'b001, 1'b0, `OP_CHECK}, s);
        check(s & 32'hFFFF, 32'h0000_8002);
        // erase suspended mid-run: query must answer, then resume must poll busy
        busyReads <= 4'h3;
        rawCmd(22'h0, 8'h20);
        rawCmd(22'h0, 8'hD0);
        rawCmd(22'h0, 8'hB0);
        rawCmd(22'h0, 8'h98);
        readWord(22'h10, q);
        check(q & 32'hFFFF, 32'h51);
        rawCmd(22'h0, 8'hD0);
        runOp(22'h0, 16'h0, {3'b001, 1'b0, `OP_CHECK}, s);
        check(s & 32'hFFFF, 32'h0000_8002);
        rawCmd(22'h0, 8'h20);
        rawCmd(22'h0, 8'h98);
        readWord(22'h10, q);
        check(q & 32'hFFFF, 32'h80);
        $display("test status check done");
        end_of_test();
    end
endmodule
